// ===== rtl/srap_pkg.sv
// shared types and constants of the serial register access port
package srap_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam int DIR_BIT = 7;
  // pointer wrap bounds per space and direction
  localparam logic [7:0] CLK_RD_LO = 8'h00;
  localparam logic [7:0] CLK_RD_HI = 8'h1f;
  localparam logic [7:0] RAM_RD_LO = 8'h20;
  localparam logic [7:0] RAM_RD_HI = 8'h7f;
  localparam logic [7:0] CLK_WR_LO = 8'h80;
  localparam logic [7:0] CLK_WR_HI = 8'h9f;
  localparam logic [7:0] RAM_WR_LO = 8'ha0;
  localparam logic [7:0] RAM_WR_HI = 8'hff;

  typedef enum logic [1:0] {
    SRAP_IDLE,
    SRAP_ADDR,
    SRAP_DATA
  } srap_phase_type;

  // synchronised pin samples
  typedef struct packed {
    logic sclk;
    logic ce;
    logic din;
  } srap_pins_type;

  // access request toward the register store
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } srap_access_type;
endpackage

// ===== rtl/srap_sync.sv
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module srap_sync
  import srap_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic reset_n, // async reset, active low
  input wire srap_pins_type async_in, // raw pins
  output srap_pins_type sync_out // synchronised pins
);
  typedef struct packed {
    srap_pins_type stage1;
    srap_pins_type stage2;
  } srap_sync_state_type;

  srap_sync_state_type state;
  srap_sync_state_type next_state;

  // first stage feeds only the second stage
  always_comb begin
    next_state.stage1 = async_in;
    next_state.stage2 = state.stage1;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign sync_out = state.stage2;
endmodule

// ===== rtl/srap_port.sv
// serial slave port: spi or three-wire access to clock registers and ram
// Behaviour
// - first byte after chip-select rises is the address, the rest are data
// - direction bit 0 means read burst, 1 means write burst
// - pointer advances by one after every data byte moved
// - auto-increment continues until chip-select drops
// - clock-space reads wrap from 1fh back to 00h
// - clock-space writes wrap from 9fh back to 80h
// - ram reads wrap from 7fh back to 20h
// - ram writes wrap from ffh back to a0h
// - bursts work in both clock and ram spaces
// - three-wire mode shares one data line for both directions
// - three-wire mode moves bytes lsb first
// - spi mode moves bytes msb first
// - three-wire samples on rising edge, drives on falling edge
// - select pin high picks spi, low picks three-wire
// - spi idle clock polarity is sampled when chip-select rises
// - spi captures on strobe edge, shifts on opposite edge, eight bits a byte
`timescale 1ns/1ps
module srap_port
  import srap_pkg::*;
(
  input wire logic clk, // 40 mhz system clock
  input wire logic reset_n, // async reset, active low
  input wire logic sclk_pin, // serial clock from host
  input wire logic ce_pin, // chip enable, active high
  input wire logic serial_in_pin, // data in, or shared line input in three-wire mode
  input wire logic interface_select_pin, // high spi, low three-wire
  output logic serial_out_pin, // data out level
  output logic serial_out_oe, // high while driving serial_out_pin
  output logic acc_wr, // one-cycle write strobe
  output logic acc_rd, // one-cycle read strobe, fetch for next byte
  output logic [ADDR_W-1:0] acc_addr, // access address
  output logic [DATA_W-1:0] acc_wdata, // write data
  input wire logic [DATA_W-1:0] acc_rdata // read data, valid cycle after acc_rd
);
  // port state apart from the pin synchroniser; the sequencer fills a copy and one flop bank holds it
  typedef struct packed {
    srap_phase_type phase;
    logic sclk_d; // previous synchronised clock
    logic ce_d;
    logic sel_meta; // select strap, first synchroniser stage
    logic sel_sync; // select strap, second stage
    logic mode_spi; // latched interface select
    logic cpol; // idle level seen at select
    logic is_read;
    logic load_pend; // high the cycle after a fetch, while read data stand
    logic [2:0] bit_cnt;
    logic [DATA_W-1:0] shift_in;
    logic [DATA_W-1:0] shift_out;
    logic [ADDR_W-1:0] ptr;
    logic dout;
    logic oe;
    srap_access_type acc;
  } srap_state_type;

  srap_state_type state;
  srap_state_type next_state;
  srap_pins_type pins_raw;
  srap_pins_type pins;

  // raw pins grouped for the shared synchroniser
  assign pins_raw.sclk = sclk_pin;
  assign pins_raw.ce = ce_pin;
  assign pins_raw.din = serial_in_pin;

  // clock, chip-select and data share one stage pair, so they stay aligned
  srap_sync u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .async_in(pins_raw),
    .sync_out(pins)
  );

  // next pointer with per-space, per-direction wrap
  // direction follows from the space: reads sit below 80h, writes above,
  // so one wrap table serves both and needs no direction input
  function automatic logic [ADDR_W-1:0] bump(input logic [ADDR_W-1:0] p);
    logic [ADDR_W-1:0] r;
    r = p + 8'h01;
    if (p == CLK_RD_HI) r = CLK_RD_LO;
    else if (p == RAM_RD_HI) r = RAM_RD_LO;
    else if (p == CLK_WR_HI) r = CLK_WR_LO;
    else if (p == RAM_WR_HI) r = RAM_WR_LO;
    return r;
  endfunction

  // pick the outgoing bit for the current bit position
  // spi sends from the top bit, three-wire from the bottom
  function automatic logic out_bit(input logic [DATA_W-1:0] d, input logic spi);
    return spi ? d[DATA_W-1] : d[0];
  endfunction

  // decoded serial clock events
  logic rise;
  logic fall;
  logic strobe;
  logic shift;
  logic [DATA_W-1:0] byte_in;

  // edges of the synchronised clock; each is seen two cycles late, so the
  // serial clock half period must span several system clocks
  assign rise = pins.sclk && !state.sclk_d;
  assign fall = !pins.sclk && state.sclk_d;

  // spi strobe is the first edge leaving idle level; three-wire fixed
  // the idle level itself is caught at select, so either polarity works
  always_comb begin
    if (state.mode_spi) begin
      strobe = state.cpol ? fall : rise;
      shift = state.cpol ? rise : fall;
    end else begin
      strobe = rise;
      shift = fall;
    end
  end

  // assembled byte including the bit being sampled now
  // the new bit enters at the end that matches the bit order
  always_comb begin
    if (state.mode_spi) begin
      byte_in = {state.shift_in[DATA_W-2:0], pins.din};
    end else begin
      byte_in = {pins.din, state.shift_in[DATA_W-1:1]};
    end
  end

  // main sequencer
  // a pin edge reaches a registered strobe about three clocks later: two
  // synchroniser stages and the output register; the edge compare is combinational
  always_comb begin
    next_state = state;
    next_state.sclk_d = pins.sclk;
    next_state.ce_d = pins.ce;
    next_state.acc.wr = 1'b0;
    next_state.acc.rd = 1'b0;
    // the store answers a fetch one cycle late, so the load trails the strobe
    next_state.load_pend = state.acc.rd;
    // mode strap through two flops; only the second stage is ever decoded
    next_state.sel_meta = interface_select_pin;
    next_state.sel_sync = state.sel_meta;
    if (!pins.ce) begin
      // deselect: drop partial byte, float output, fresh address next time
      // the pointer is kept, but the next address byte overwrites it anyway
      next_state.phase = SRAP_IDLE;
      next_state.bit_cnt = '0;
      next_state.oe = 1'b0;
      next_state.is_read = 1'b0;
    end else if (!state.ce_d) begin
      // select edge: catch mode and idle clock level
      // bits clocked in before the select is seen are never counted
      next_state.phase = SRAP_ADDR;
      next_state.mode_spi = state.sel_sync;
      next_state.cpol = pins.sclk;
      next_state.bit_cnt = '0;
      next_state.oe = 1'b0;
    end else begin
      if (state.load_pend) begin
        next_state.shift_out = acc_rdata;
      end
      // strobes in idle are ignored, which also hides the false edge after reset
      if (strobe && state.phase != SRAP_IDLE) begin
        next_state.shift_in = byte_in;
        next_state.bit_cnt = state.bit_cnt + 3'h1;
        if (state.bit_cnt == BIT_LAST) begin
          if (state.phase == SRAP_ADDR) begin
            next_state.phase = SRAP_DATA;
            next_state.ptr = byte_in;
            next_state.is_read = !byte_in[DIR_BIT];
            if (!byte_in[DIR_BIT]) begin
              next_state.acc.rd = 1'b1;
              next_state.acc.addr = byte_in;
            end
          end else if (!state.is_read) begin
            // complete data byte commits, then pointer moves on
            next_state.acc.wr = 1'b1;
            next_state.acc.addr = state.ptr;
            next_state.acc.wdata = byte_in;
            next_state.ptr = bump(state.ptr);
          end else begin
            // fetch next read byte from the bumped pointer
            next_state.ptr = bump(state.ptr);
            next_state.acc.rd = 1'b1;
            next_state.acc.addr = bump(state.ptr);
          end
        end
      end
      // read data driven on shift edges; first bit on edge after address
      // a load lands three clocks after its strobe edge, ahead of the next
      // shift edge, which the minimum clock half period keeps apart
      if (shift && state.phase == SRAP_DATA && state.is_read) begin
        next_state.oe = 1'b1;
        next_state.dout = out_bit(state.shift_out, state.mode_spi);
        if (state.mode_spi) begin
          next_state.shift_out = {state.shift_out[DATA_W-2:0], 1'b0};
        end else begin
          next_state.shift_out = {1'b0, state.shift_out[DATA_W-1:1]};
        end
      end
    end
  end

  // one register bank for all state but the pin synchroniser; reset leaves the output released
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // all outputs straight from the state register
  assign serial_out_pin = state.dout;
  assign serial_out_oe = state.oe;
  assign acc_wr = state.acc.wr;
  assign acc_rd = state.acc.rd;
  assign acc_addr = state.acc.addr;
  assign acc_wdata = state.acc.wdata;
endmodule

// ===== testbench/srap_monitor.sv
// checker for srap_port
`timescale 1ns/1ps
module srap_monitor
  import srap_pkg::*;
(
  input wire logic clk, // clock
  input wire logic reset_n, // reset
  input wire logic ce_pin, // enable
  input wire logic serial_out_oe, // oe
  input wire logic acc_wr, // write
  input wire logic acc_rd, // read
  input wire logic [ADDR_W-1:0] acc_addr // address
);
  logic wv;
  logic [ADDR_W-1:0] wl;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // next write address; each space wraps inside itself
  function automatic logic [7:0] step(input logic [7:0] a);
    return a == CLK_WR_HI ? CLK_WR_LO : a == RAM_WR_HI ? RAM_WR_LO : a + 8'h01;
  endfunction
  // last write address; a new selection starts a new chain, its address is free
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) {wv, wl} <= 9'h000;
    else begin
      wv <= acc_wr || (wv && !$rose(ce_pin));
      if (acc_wr) wl <= acc_addr;
    end
  end
  sequence deselected; !ce_pin [*6]; endsequence
  sequence addr_phase; !serial_out_oe [*8]; endsequence
  wr_pulse_a: assert property (acc_wr |=> !acc_wr) else $error("long wr");
  rd_pulse_a: assert property (acc_rd |=> !acc_rd) else $error("long rd");
  strobe_excl_a: assert property (!(acc_wr && acc_rd)) else $error("two strobes");
  wr_step_a: assert property (acc_wr && wv |-> acc_addr == step(wl))
    else $error("bad step");
  wr_space_a: assert property (acc_wr |-> acc_addr[DIR_BIT]) else $error("wr space");
  rd_space_a: assert property (acc_rd |-> !acc_addr[DIR_BIT]) else $error("rd space");
  oe_release_a: assert property (deselected |-> !serial_out_oe) else $error("oe");
  oe_quiet_a: assert property ($rose(ce_pin) |=> addr_phase) else $error("oe");
  strobe_quiet_a: assert property (deselected |-> !acc_wr && !acc_rd)
    else $error("strobe while deselected");
endmodule
bind srap_port srap_monitor u_srap_monitor (.clk, .reset_n, .ce_pin, .serial_out_oe, .acc_wr,
  .acc_rd, .acc_addr);

// ===== testbench/srap_host.sv
// host master model for srap_port
`timescale 1ns/1ps
module srap_host (
  input wire logic clk, // pacing clock
  input wire logic rx, // read level
  output logic sclk, // serial clock
  output logic ce, // chip enable
  output logic tx // host data
);
  logic [7:0] rd [4]; // bytes read
  logic tw = 1'b0; // three-wire
  initial {sclk, ce, tx} = 3'h0;
  // address then n bytes; tail > 0 cuts the last byte short
  task automatic frame(input logic mode3, input logic pol, input logic [7:0] addr,
    input int n, input int tail);
    logic [7:0] b;
    tw = mode3;
    sclk <= mode3 ? 1'b0 : pol;
    repeat (4) @(posedge clk);
    ce <= 1'b1;
    repeat (8) @(posedge clk);
    for (int k = 0; k <= n; k++) begin
      b = k == 0 ? addr : 8'h10 + 8'(k);
      for (int i = 0; i < (k == n && tail > 0 ? tail : 8); i++) begin
        // next bit goes out one slot, two clocks, ahead of the strobe edge in both modes
        tx <= tw ? b[i] : b[7 - i];
        // slots of two clocks; reads wait two clocks past the edge for the output
        for (int p = 0; p < 4; p++) begin
          repeat (2) @(posedge clk);
          if (p % 2 == 0) sclk <= ~sclk;
          if (p == (tw ? 1 : 3)) rd[k][tw ? i : 7 - i] = rx;
        end
      end
    end
    repeat (4) @(posedge clk);
    ce <= 1'b0;
    repeat (12) @(posedge clk);
  endtask
endmodule

// ===== testbench/testbench.sv
// bench for srap_port
`timescale 1ns/1ps
module testbench
  import srap_pkg::*;
;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic sel = 1'b1;
  logic sclk, ce, tx, so, oe, acc_wr, acc_rd;
  logic [ADDR_W-1:0] acc_addr;
  logic [DATA_W-1:0] acc_wdata;
  logic [DATA_W-1:0] acc_rdata = 8'h00;
  logic [15:0] wlog [$];
  int err_total = 0, samples_checked = 0, cycles = 0;
  // shared line in three-wire; a released output reads inverted
  wire logic din = oe && !sel ? so : tx;
  wire logic rx = oe ? so : ~so;
  always #12.5 clk = ~clk;
  srap_port u_srap_port (.clk, .reset_n, .sclk_pin(sclk), .ce_pin(ce), .serial_in_pin(din),
    .interface_select_pin(sel), .serial_out_pin(so), .serial_out_oe(oe), .acc_wr, .acc_rd,
    .acc_addr, .acc_wdata, .acc_rdata);
  srap_host u_srap_host (.clk, .rx, .sclk, .ce, .tx);
  // store stand-in: answers a fetch next cycle, logs writes, cuts a hang
  always @(posedge clk) begin
    if (acc_rd) acc_rdata <= acc_addr ^ 8'h5a;
    if (acc_wr) wlog.push_back({acc_addr, acc_wdata});
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      $display("unexpected at %0t: hang", $time);
      final_report();
    end
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic check_writes(input int n, input logic [15:0] e [4]);
    check(16'(wlog.size()), 16'(n));
    for (int i = 0; i < n; i++) check(wlog[i], e[i]);
    wlog.delete();
  endtask
  task automatic spi_bursts();
    sel <= 1'b1;
    u_srap_host.frame(1'b0, 1'b0, 8'h9e, 3, 0);
    u_srap_host.frame(1'b0, 1'b0, 8'h85, 1, 4);
    u_srap_host.frame(1'b0, 1'b1, 8'h81, 1, 0);
    check_writes(4, '{16'h9e11, 16'h9f12, 16'h8013, 16'h8111});
    u_srap_host.frame(1'b0, 1'b0, 8'h3c, 1, 0);
    check({8'h00, u_srap_host.rd[1]}, 16'h0066);
    u_srap_host.frame(1'b0, 1'b1, 8'h7f, 2, 0);
    check({u_srap_host.rd[1], u_srap_host.rd[2]}, 16'h257a);
  endtask
  task automatic three_wire();
    sel <= 1'b0;
    u_srap_host.frame(1'b1, 1'b0, 8'hfe, 3, 0);
    check_writes(3, '{16'hfe11, 16'hff12, 16'ha013, 16'h0});
    u_srap_host.frame(1'b1, 1'b0, 8'h1f, 2, 0);
    check({u_srap_host.rd[1], u_srap_host.rd[2]}, 16'h455a);
    check_writes(0, '{16'h0, 16'h0, 16'h0, 16'h0});
  endtask
  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    spi_bursts();
    three_wire();
    final_report();
  end
  task automatic final_report();
    if (err_total == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
endmodule
